// >>> logic/dms_consts.vh
// constants for the drive operation mode selector: register map, fields, codes
// assumes inclusion by the selector module only; definitions, no logic
`ifndef DMS_CONSTS_VH
`define DMS_CONSTS_VH

// ----------------------------------------------------------------
// register word offsets (byte address bits 7:2)
// ----------------------------------------------------------------
`define DMS_REG_MODE_SET 6'h00
`define DMS_REG_STATUS 6'h01
`define DMS_REG_PARAM_REQ 6'h02
`define DMS_REG_NET_CMD 6'h03
`define DMS_REG_CONFIG 6'h04
`define DMS_REG_PANEL_FREQ 6'h05
`define DMS_REG_NET_FREQ 6'h06

// ----------------------------------------------------------------
// operation mode setting values
// ----------------------------------------------------------------
`define DMS_SET_SWITCH 3'h0
`define DMS_SET_PANEL 3'h1
`define DMS_SET_EXT_FIX 3'h2
`define DMS_SET_COMB1 3'h3
`define DMS_SET_COMB2 3'h4
`define DMS_SET_RUNSW 3'h6
`define DMS_SET_ILOCK 3'h7
`define DMS_SET_RST 3'h0

// ----------------------------------------------------------------
// network command codes (net_cmd bits 1:0)
// ----------------------------------------------------------------
`define DMS_NCMD_EXT 2'h1
`define DMS_NCMD_NET 2'h2

// ----------------------------------------------------------------
// config fields and reset value
// ----------------------------------------------------------------
`define DMS_CFG_STOP_ALL 0
`define DMS_CFG_IND_NEG 1
`define DMS_CFG_IL_TERM 2
`define DMS_CFG_WR_RUN 3
`define DMS_CFG_RST 4'h1

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define DMS_ST_CHG_REJ 8
`define DMS_ST_SET_REJ 9
`define DMS_ST_PAR_OK 10
`define DMS_ST_PAR_REJ 11

// widths
`define DMS_FW 16
`define DMS_FREQ_RST 16'h0000

`endif

// >>> logic/dms_mode_sel.v
// drive operation mode selector: picks start and frequency source per mode
// assumes synchronous inputs on clk_i, key inputs are one-cycle pulses,
// registers reached over classic wishbone with 32-bit data
//
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ns
`include "dms_consts.vh"

module dms_mode_sel (
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // terminals
  input wire forward_start_input_i,
  input wire reverse_start_input_i,
  input wire output_stop_input_i,
  input wire panel_interlock_input_i,
  input wire current_input_select_i,
  input wire pid_enable_input_i,
  input wire [3:0] multi_speed_inputs_i,
  input wire [15:0] analog_freq_i,
  input wire [15:0] term4_freq_i,
  input wire [15:0] multi_speed_freq_i,
  input wire [15:0] pid_freq_i,
  input wire motor_running_i,
  // panel keys, one-cycle pulses
  input wire panel_mode_key_i,
  input wire panel_fwd_key_i,
  input wire panel_rev_key_i,
  input wire panel_stop_key_i,
  // drive outputs
  output reg [2:0] op_mode_o,
  output reg run_fwd_o,
  output reg run_rev_o,
  output reg [15:0] freq_cmd_o,
  output reg output_stop_o,
  output reg panel_mode_ind_o,
  output reg stop_req_o
);

  // ----------------------------------------------------------------
  // mode states, one-hot
  // ----------------------------------------------------------------
  localparam [2:0] ST_EXT = 3'b001;
  localparam [2:0] ST_PNL = 3'b010;
  localparam [2:0] ST_NET = 3'b100;

  reg [2:0] mode_q, mode_d;
  reg [2:0] set_q;
  reg [3:0] cfg_q;
  reg [15:0] pnl_freq_q, net_freq_q, hold_freq_q, hold_freq_d;
  reg [1:0] hold_dir_q, hold_dir_d;
  reg carry_q, carry_d;
  reg [1:0] pnl_run_q;
  reg [1:0] net_run_q;
  reg chg_rej_q, set_rej_q, par_ok_q, par_rej_q;
  reg ack_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // writes land on the edge that raises ack, once per cycle
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = bus_req & wb_we_i;
  wire [5:0] widx = wb_adr_i[7:2];
  wire wr_set = wr & wb_sel_i[0] & (widx == `DMS_REG_MODE_SET);
  wire wr_stat = wr & wb_sel_i[1] & (widx == `DMS_REG_STATUS);
  wire wr_par = wr & wb_sel_i[0] & (widx == `DMS_REG_PARAM_REQ);
  wire wr_net = wr & wb_sel_i[0] & (widx == `DMS_REG_NET_CMD);
  wire wr_cfg = wr & wb_sel_i[0] & (widx == `DMS_REG_CONFIG);
  wire wr_pf = wr & (widx == `DMS_REG_PANEL_FREQ);
  wire wr_nf = wr & (widx == `DMS_REG_NET_FREQ);
  wire stopped = ~motor_running_i;

  // ----------------------------------------------------------------
  // interlock source and setting checks
  // ----------------------------------------------------------------
  // without an assigned terminal the output-stop input doubles as interlock
  wire ilock = cfg_q[`DMS_CFG_IL_TERM] ? panel_interlock_input_i : output_stop_input_i;
  wire set_il = (set_q == `DMS_SET_ILOCK);
  wire il_off = set_il & ~ilock;
  wire [2:0] new_set = wb_dat_i[2:0];
  // value 5 and anything with upper bits is not a supported setting
  wire set_valid = (wb_dat_i[31:3] == 29'h0) && (new_set != 3'h5);
  wire set_ok = wr_set & set_valid & stopped;

  // ----------------------------------------------------------------
  // change requests from panel key and network command
  // ----------------------------------------------------------------
  reg [2:0] req_tgt;
  reg req_v;
  reg allow;
  always @* begin
    req_tgt = ST_EXT;
    req_v = 1'b0;
    if (wr_net && wb_dat_i[1:0] == `DMS_NCMD_EXT) begin
      req_tgt = ST_EXT;
      req_v = 1'b1;
    end else if (wr_net && wb_dat_i[1:0] == `DMS_NCMD_NET) begin
      req_tgt = ST_NET;
      req_v = 1'b1;
    end else if (panel_mode_key_i) begin
      req_tgt = (mode_q == ST_PNL) ? ST_EXT : ST_PNL;
      req_v = 1'b1;
    end
  end

  // which settings permit the requested change
  always @* begin
    case (set_q)
      `DMS_SET_SWITCH: allow = stopped;
      `DMS_SET_EXT_FIX: allow = stopped & (req_tgt != ST_PNL);
      `DMS_SET_RUNSW: allow = 1'b1;
      `DMS_SET_ILOCK: allow = ilock & stopped;
      default: allow = 1'b0; // settings 1, 3, 4 fixed
    endcase
  end

  // ----------------------------------------------------------------
  // frequency and start source selection
  // ----------------------------------------------------------------
  wire ms_on = |multi_speed_inputs_i;
  reg [15:0] ext_freq, cur_freq;
  reg [1:0] cur_dir;
  always @* begin
    // plain external: multi-speed over terminal 4 (when selected) over terminal 2
    if (ms_on) begin
      ext_freq = multi_speed_freq_i;
    end else if (current_input_select_i) begin
      ext_freq = term4_freq_i;
    end else begin
      ext_freq = analog_freq_i;
    end
    cur_freq = ext_freq;
    cur_dir = {reverse_start_input_i, forward_start_input_i};
    case (mode_q)
      ST_EXT: begin
        if (set_q == `DMS_SET_COMB1) begin
          // panel value is the last resort behind multi-speed, PID and terminal 4, in place of terminal 2
          if (ms_on) begin
            cur_freq = multi_speed_freq_i;
          end else if (pid_enable_input_i) begin
            cur_freq = pid_freq_i;
          end else if (current_input_select_i) begin
            cur_freq = term4_freq_i;
          end else begin
            cur_freq = pnl_freq_q;
          end
        end else if (set_q == `DMS_SET_COMB2) begin
          cur_dir = pnl_run_q;
        end
      end
      ST_PNL: begin
        cur_freq = carry_q ? hold_freq_q : pnl_freq_q;
        cur_dir = carry_q ? hold_dir_q : pnl_run_q;
      end
      ST_NET: begin
        cur_freq = carry_q ? hold_freq_q : net_freq_q;
        cur_dir = carry_q ? hold_dir_q : net_run_q;
      end
      default: begin
        cur_freq = ext_freq;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next mode and carried values
  // ----------------------------------------------------------------
  wire stop_ok = panel_stop_key_i & (cfg_q[`DMS_CFG_STOP_ALL] | (mode_q == ST_PNL));
  wire do_chg = ~set_ok & ~il_off & req_v & allow & (req_tgt != mode_q);
  always @* begin
    mode_d = mode_q;
    carry_d = carry_q;
    hold_freq_d = hold_freq_q;
    hold_dir_d = hold_dir_q;
    if (set_ok) begin
      // a new setting restarts from its power-on mode, carried value dropped
      mode_d = (new_set == `DMS_SET_PANEL) ? ST_PNL : ST_EXT;
      carry_d = 1'b0;
    end else if (il_off) begin
      mode_d = ST_EXT;
      carry_d = 1'b0;
    end else if (do_chg) begin
      mode_d = req_tgt;
      if (req_tgt == ST_EXT) begin
        carry_d = 1'b0; // terminals take over
      end else begin
        // keep what was in effect so operation is not interrupted
        carry_d = motor_running_i;
        hold_freq_d = cur_freq;
        hold_dir_d = cur_dir;
      end
    end else begin
      // a fresh setpoint from the owning source ends the carry
      if ((wr_pf && mode_q == ST_PNL) || (wr_nf && mode_q == ST_NET) || stop_ok) begin
        carry_d = 1'b0;
      end
    end
  end

  // parameter write gate
  wire par_allow = ~il_off & (stopped | cfg_q[`DMS_CFG_WR_RUN]) &
    ((mode_q != ST_EXT) | wb_dat_i[0]);

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // carried values are plain flops, so any reset loses them
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= ST_EXT;
      set_q <= `DMS_SET_RST;
      cfg_q <= `DMS_CFG_RST;
      pnl_freq_q <= `DMS_FREQ_RST;
      net_freq_q <= `DMS_FREQ_RST;
      hold_freq_q <= `DMS_FREQ_RST;
      hold_dir_q <= 2'h0;
      carry_q <= 1'b0;
      pnl_run_q <= 2'h0;
      net_run_q <= 2'h0;
      chg_rej_q <= 1'b0;
      set_rej_q <= 1'b0;
      par_ok_q <= 1'b0;
      par_rej_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      carry_q <= carry_d;
      hold_freq_q <= hold_freq_d;
      hold_dir_q <= hold_dir_d;
      if (set_ok) begin
        set_q <= new_set;
      end
      if (wr_set) begin
        set_rej_q <= ~set_ok;
      end
      if (wr_cfg) begin
        cfg_q <= wb_dat_i[3:0];
      end
      if (wr_pf && wb_sel_i[0]) begin
        pnl_freq_q[7:0] <= wb_dat_i[7:0];
      end
      if (wr_pf && wb_sel_i[1]) begin
        pnl_freq_q[15:8] <= wb_dat_i[15:8];
      end
      if (wr_nf && wb_sel_i[0]) begin
        net_freq_q[7:0] <= wb_dat_i[7:0];
      end
      if (wr_nf && wb_sel_i[1]) begin
        net_freq_q[15:8] <= wb_dat_i[15:8];
      end
      if (wr_net) begin
        net_run_q <= wb_dat_i[5:4];
      end
      // panel start latch; an honoured stop key (stop_ok) wins over a start key
      if (stop_ok) begin
        pnl_run_q <= 2'h0;
      end else if (panel_fwd_key_i) begin
        pnl_run_q <= 2'b01;
      end else if (panel_rev_key_i) begin
        pnl_run_q <= 2'b10;
      end
      // refused change: the set beats a same-cycle clear
      if (req_v && ~set_ok && (il_off || ~allow) && req_tgt != mode_q) begin
        chg_rej_q <= 1'b1;
      end else if (wr_stat && wb_dat_i[`DMS_ST_CHG_REJ]) begin
        chg_rej_q <= 1'b0;
      end
      if (wr_par) begin
        par_ok_q <= par_allow;
        par_rej_q <= ~par_allow;
      end
    end
  end

  // ----------------------------------------------------------------
  // drive outputs, all registered
  // ----------------------------------------------------------------
  // without an interlock terminal, interlock mode borrows the output-stop input, so its normal meaning drops
  wire mrs_stop = output_stop_input_i & ~(set_il & ~cfg_q[`DMS_CFG_IL_TERM]);
  wire stop_now = mrs_stop | (set_il & ilock & (mode_d == ST_EXT));
  always @(posedge clk_i) begin
    if (rst_i) begin
      op_mode_o <= ST_EXT;
      run_fwd_o <= 1'b0;
      run_rev_o <= 1'b0;
      freq_cmd_o <= `DMS_FREQ_RST;
      output_stop_o <= 1'b0;
      panel_mode_ind_o <= 1'b0;
      stop_req_o <= 1'b0;
    end else begin
      op_mode_o <= mode_d;
      // both directions at once means no run
      run_fwd_o <= cur_dir[0] & ~cur_dir[1] & ~stop_now;
      run_rev_o <= cur_dir[1] & ~cur_dir[0] & ~stop_now;
      freq_cmd_o <= cur_freq;
      output_stop_o <= stop_now;
      panel_mode_ind_o <= (mode_d == ST_PNL) ^ cfg_q[`DMS_CFG_IND_NEG];
      stop_req_o <= stop_ok;
    end
  end

  // ----------------------------------------------------------------
  // wishbone answer: one wait state, unmapped reads zero
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_q <= bus_req;
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0;
      if (bus_req && !wb_we_i) begin
        case (widx)
          `DMS_REG_MODE_SET: wb_dat_o <= {29'h0, set_q};
          `DMS_REG_STATUS: wb_dat_o <= {20'h0, par_rej_q, par_ok_q, set_rej_q, chg_rej_q,
            motor_running_i, ilock, carry_q, 2'h0, mode_q};
          `DMS_REG_NET_CMD: wb_dat_o <= {26'h0, net_run_q, 4'h0};
          `DMS_REG_CONFIG: wb_dat_o <= {28'h0, cfg_q};
          `DMS_REG_PANEL_FREQ: wb_dat_o <= {16'h0, pnl_freq_q};
          `DMS_REG_NET_FREQ: wb_dat_o <= {16'h0, net_freq_q};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

endmodule

// >>> tb/dms_mode_sel_props.sv
// checker for the mode selector: bus handshake and mode rules at the ports
// assumes a bind onto dms_mode_sel; the setting is shadowed from bus writes
`timescale 1ns/1ns
module dms_mode_sel_props (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire output_stop_input_i,
  input wire panel_interlock_input_i,
  input wire motor_running_i,
  input wire panel_mode_key_i,
  input wire panel_stop_key_i,
  input wire [2:0] op_mode_o,
  input wire run_fwd_o,
  input wire run_rev_o,
  input wire stop_req_o
);
  // ----------------------------------------------------------------
  // shadow setting
  // ----------------------------------------------------------------
  reg [2:0] set_q;
  wire set_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i[7:2] == 6'h00 &&
    wb_dat_i[31:3] == 29'h0 && wb_dat_i[2:0] != 3'h5 && !motor_running_i;
  // follows the setting on the very edge that takes the write, so mode and setting move together
  always @(posedge clk_i) begin
    if (rst_i)
      set_q <= 3'h0;
    else if (set_wr)
      set_q <= wb_dat_i[2:0];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_reset_external: assert property ($past(rst_i) |-> op_mode_o == 3'b001)
    else $error("mode not external after reset");
  a_fixed_panel: assert property (set_q == 3'h1 |-> op_mode_o == 3'b010)
    else $error("fixed panel setting left panel mode");
  a_no_panel_lock: assert property (set_q == 3'h2 |-> !op_mode_o[1])
    else $error("locked external setting reached panel mode");
  a_key_toggles: assert property (set_q == 3'h0 && panel_mode_key_i && !motor_running_i &&
    (op_mode_o == 3'b001 || op_mode_o == 3'b010) |=> op_mode_o == ($past(op_mode_o) ^ 3'b011))
    else $error("mode key did not toggle");
  a_combined_fixed: assert property (set_q == 3'h3 || set_q == 3'h4 |-> op_mode_o == 3'b001)
    else $error("combined setting changed mode");
  a_ilock_forces: assert property (set_q == 3'h7 && !output_stop_input_i && !panel_interlock_input_i
    |=> op_mode_o == 3'b001) else $error("interlock off did not force external");
  a_stop_key_all: assert property (panel_stop_key_i |=> stop_req_o)
    else $error("stop key not honoured");
  a_out_stop_run: assert property ($past(output_stop_input_i) && set_q != 3'h7 |-> !run_fwd_o && !run_rev_o)
    else $error("run command during output stop");
  a_set_wr_running: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
    wb_adr_i[7:2] == 6'h00 && motor_running_i |=> $stable(op_mode_o)) else $error("setting write while running");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
endmodule

bind dms_mode_sel dms_mode_sel_props dms_mode_sel_props_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o),
  .output_stop_input_i(output_stop_input_i), .panel_interlock_input_i(panel_interlock_input_i),
  .motor_running_i(motor_running_i), .panel_mode_key_i(panel_mode_key_i), .panel_stop_key_i(panel_stop_key_i),
  .op_mode_o(op_mode_o), .run_fwd_o(run_fwd_o), .run_rev_o(run_rev_o), .stop_req_o(stop_req_o));

// >>> tb/dms_far_side.sv
// far-side model: operator panel keys and a motor following the run outputs
// assumes keys 0 mode, 1 forward, 2 reverse, 3 stop; bench calls press
`timescale 1ns/1ns
module dms_far_side (
  input wire clk_i,
  input wire run_fwd_i,
  input wire run_rev_i,
  output reg [3:0] key_o,
  output reg motor_running_o
);
  initial key_o = 4'h0;
  initial motor_running_o = 1'b0;
  // motor needs a cycle to react, so running lags the run command
  always @(posedge clk_i) begin
    motor_running_o <= run_fwd_i | run_rev_i;
  end
  // one-cycle key pulse launched just after an edge
  task press(input integer k);
    begin
      @(posedge clk_i);
      key_o[k] <= 1'b1;
      @(posedge clk_i);
      key_o[k] <= 1'b0;
      #1;
    end
  endtask
endmodule

// >>> tb/dms_mode_sel_tb.sv
// bench for the mode selector: wishbone tasks, terminal levels, panel keys
// assumes the checker is bound and the far-side model drives keys and motor
`timescale 1ns/1ns
module dms_mode_sel_tb;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc = 1'b0, stb = 1'b0, we = 1'b0, fwd = 1'b0, ostop = 1'b0, ilock = 1'b0, csel = 1'b0, pid = 1'b0;
  reg rev = 1'b0;
  reg [3:0] sel = 4'hf;
  reg [7:0] adr = 8'h00;
  reg [31:0] dat = 32'h0, q;
  reg [3:0] ms = 4'h0;
  reg [15:0] ana = 16'h0321, t4 = 16'h0444, msf = 16'h0555, pidf = 16'h0666;
  wire [31:0] rdat;
  wire ack, rf, rr, ostop_o, ind, sreq, run;
  wire [2:0] mode;
  wire [15:0] freq;
  wire [3:0] key;
  integer failures = 0, checks_done = 0;
  // 4 ns period
  always #2 clk_i = ~clk_i;
  dms_far_side dms_far_side_i (.clk_i(clk_i), .run_fwd_i(rf), .run_rev_i(rr), .key_o(key), .motor_running_o(run));
  dms_mode_sel dms_mode_sel_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .forward_start_input_i(fwd), .reverse_start_input_i(rev), .output_stop_input_i(ostop),
    .panel_interlock_input_i(ilock), .current_input_select_i(csel), .pid_enable_input_i(pid),
    .multi_speed_inputs_i(ms), .analog_freq_i(ana), .term4_freq_i(t4), .multi_speed_freq_i(msf),
    .pid_freq_i(pidf), .motor_running_i(run), .panel_mode_key_i(key[0]), .panel_fwd_key_i(key[1]),
    .panel_rev_key_i(key[2]), .panel_stop_key_i(key[3]), .op_mode_o(mode), .run_fwd_o(rf),
    .run_rev_o(rr), .freq_cmd_o(freq), .output_stop_o(ostop_o), .panel_mode_ind_o(ind), .stop_req_o(sreq));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  // classic single cycle; request held until ack is sampled high
  task bus(input [7:0] a, input [31:0] d, input w);
    integer n;
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      n = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk_i);
      end
      if (n == 20) failures = failures + 1;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    failures = failures + 1;
    end_sim;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    chk(mode, 3'b001);
    bus(8'h10, 0, 0);
    chk(q, 32'h1);
    bus(8'h3c, 0, 0);
    chk(q, 32'h0);
    bus(8'h08, 32'h0, 1);
    bus(8'h04, 0, 0);
    chk(q[11:10], 2'b10);
    bus(8'h08, 32'h1, 1);
    bus(8'h04, 0, 0);
    chk(q[11:10], 2'b01);
    dms_far_side_i.press(0);
    tick(1);
    chk({mode, ind}, {3'b010, 1'b1});
    dms_far_side_i.press(0);
    tick(1);
    chk({mode, freq}, {3'b001, 16'h0321});
    bus(8'h10, 32'h3, 1);
    tick(1);
    chk(ind, 1'b1);
    bus(8'h10, 32'h1, 1);
    dms_far_side_i.press(3);
    chk(sreq, 1'b1);
    bus(8'h00, 32'h2, 1);
    dms_far_side_i.press(0);
    chk(mode, 3'b001);
    bus(8'h0c, 32'h2, 1);
    chk(mode, 3'b100);
    bus(8'h0c, 32'h1, 1);
    chk(mode, 3'b001);
    bus(8'h00, 32'h1, 1);
    dms_far_side_i.press(0);
    bus(8'h0c, 32'h1, 1);
    chk(mode, 3'b010);
    bus(8'h00, 32'h5, 1);
    bus(8'h04, 0, 0);
    chk(q[9], 1'b1);
    bus(8'h00, 0, 0);
    chk(q[2:0], 3'h1);
    // combined setting: source priority walked upward
    bus(8'h00, 32'h3, 1);
    bus(8'h14, 32'h0100, 1);
    tick(2);
    chk(freq, 16'h0100);
    // high byte lane only: low byte of the panel value must survive
    @(posedge clk_i) sel <= 4'h2;
    bus(8'h14, 32'h02ff, 1);
    sel <= 4'hf;
    tick(2);
    chk(freq, 16'h0200);
    @(posedge clk_i) csel <= 1'b1;
    t4 <= 16'h0445;
    tick(2);
    chk(freq, 16'h0445);
    @(posedge clk_i) pid <= 1'b1;
    pidf <= 16'h0667;
    tick(2);
    chk(freq, 16'h0667);
    @(posedge clk_i) ms <= 4'h2;
    msf <= 16'h0556;
    tick(2);
    chk(freq, 16'h0556);
    bus(8'h00, 32'h4, 1);
    dms_far_side_i.press(0);
    chk(mode, 3'b001);
    // panel keys give the start command in this setting
    dms_far_side_i.press(2);
    tick(1);
    chk({rf, rr}, 2'b01);
    dms_far_side_i.press(3);
    // switch-over while running, frequency carried
    @(posedge clk_i) ms <= 4'h0;
    pid <= 1'b0;
    csel <= 1'b0;
    bus(8'h00, 32'h6, 1);
    @(posedge clk_i) fwd <= 1'b1;
    tick(3);
    dms_far_side_i.press(0);
    @(posedge clk_i) ana <= 16'h0123;
    tick(2);
    chk({mode, rf, freq}, {3'b010, 1'b1, 16'h0321});
    bus(8'h00, 32'h0, 1);
    bus(8'h04, 0, 0);
    chk(q[9], 1'b1);
    bus(8'h0c, 32'h2, 1);
    tick(1);
    chk({mode, rf, freq}, {3'b100, 1'b1, 16'h0321});
    dms_far_side_i.press(0);
    tick(1);
    chk({mode, rf, freq}, {3'b010, 1'b1, 16'h0321});
    bus(8'h0c, 32'h1, 1);
    tick(1);
    chk({mode, freq}, {3'b001, 16'h0123});
    bus(8'h0c, 32'h2, 1);
    @(posedge clk_i) ana <= 16'h0321;
    tick(2);
    chk({mode, freq}, {3'b100, 16'h0123});
    bus(8'h0c, 32'h1, 1);
    // terminals own the direction again, then output stop cuts the run
    @(posedge clk_i) rev <= 1'b1;
    fwd <= 1'b0;
    tick(2);
    chk({rf, rr}, 2'b01);
    @(posedge clk_i) ostop <= 1'b1;
    tick(2);
    chk({rr, ostop_o}, 2'b01);
    @(posedge clk_i) ostop <= 1'b0;
    rev <= 1'b0;
    tick(4);
    // interlock setting, output-stop input as interlock first
    bus(8'h00, 32'h7, 1);
    dms_far_side_i.press(0);
    chk(mode, 3'b001);
    bus(8'h08, 32'h1, 1);
    bus(8'h04, 0, 0);
    chk(q[11:10], 2'b10);
    @(posedge clk_i) ostop <= 1'b1;
    tick(2);
    chk(ostop_o, 1'b1);
    dms_far_side_i.press(0);
    tick(1);
    chk({mode, ostop_o}, {3'b010, 1'b0});
    @(posedge clk_i) ilock <= 1'b1;
    bus(8'h10, 32'h5, 1);
    @(posedge clk_i) ostop <= 1'b0;
    tick(2);
    chk(mode, 3'b010);
    @(posedge clk_i) ilock <= 1'b0;
    tick(2);
    chk(mode, 3'b001);
    end_sim;
  end
endmodule
